// ---- core/ocmon_pkg.sv ----
package ocmon_pkg;
   localparam int NUM_CH = 4;
   localparam int DLY_W = 7;
   // Command codes that select the byte registers.
   localparam logic [7:0] CMD_STATUS = 8'h00;
   localparam logic [7:0] CMD_CONFIG = 8'h01;
   localparam logic [7:0] CMD_QDELAY = 8'h02;
   // Power-on values.
   localparam logic [7:0] CONFIG_RST = 8'h0C;
   localparam logic [7:0] QDELAY_RST = 8'h04;
   // Field positions.
   localparam int ALERT_EN_BIT = 3;
   localparam int AVG_LSB = 0;
   localparam int AVG_W = 3;
   localparam int CNT_RESET_BIT = 7;
   localparam int QDLY_LSB = 0;
   // Qualification takes one sample per channel every millisecond.
   localparam int SAMPLE_PERIOD_US = 1000;
   localparam int CLK_MHZ = 125;
   localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_US * CLK_MHZ;
endpackage

// ---- core/oc_qualifier.sv ----
module oc_qualifier
   import ocmon_pkg::*;
(
   input wire logic i_clk, // System clock.
   input wire logic i_nrst, // Sync reset, active low.
   input wire logic i_hold, // Hold counter in reset.
   input wire logic [ocmon_pkg::DLY_W-1:0] i_delay, // Qualify delay value.
   input wire logic i_sample_stb, // One sample this cycle.
   input wire logic i_over, // Sample exceeds threshold.
   output logic o_qualified // Pulse: excursion qualified.
);
   logic [DLY_W-1:0] cnt_q;
   logic fired_q;

   // Once an excursion has fired, further exceeding samples are ignored until
   // a sample falls below the threshold or i_hold restarts qualification, so
   // without a hold in between one excursion gives one event.
   // The count is compared with at least the delay, so a delay lowered in
   // mid-excursion to no more than the count already reached fires on the next exceeding sample instead of waiting
   // for the counter to wrap around.
   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_hold) begin
         cnt_q <= '0;
         fired_q <= 1'b0;
         o_qualified <= 1'b0;
      end else begin
         o_qualified <= 1'b0;
         if (i_sample_stb) begin
            if (!i_over) begin
               cnt_q <= '0;
               fired_q <= 1'b0;
            end else if (!fired_q) begin
               if (cnt_q >= i_delay) begin
                  o_qualified <= 1'b1;
                  fired_q <= 1'b1;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   property p_zero_delay_fires;
      i_delay == '0 && i_sample_stb && i_over && !fired_q && !i_hold
         |=> o_qualified;
   endproperty
   a_zero_delay_fires: assert property (p_zero_delay_fires)
      else $error("Zero delay did not qualify on the first sample.");

   property p_count_reaches_delay;
      cnt_q >= i_delay && i_sample_stb && i_over && !fired_q && !i_hold
         |=> o_qualified && cnt_q == '0;
   endproperty
   a_count_reaches_delay: assert property (p_count_reaches_delay)
      else $error("Delay count reached without qualification.");

   property p_early_no_fire;
      cnt_q < i_delay |=> !o_qualified;
   endproperty
   a_early_no_fire: assert property (p_early_no_fire)
      else $error("Qualified before the programmed delay.");

   property p_low_sample_restarts;
      i_sample_stb && !i_over |=> cnt_q == '0 && !fired_q && !o_qualified;
   endproperty
   a_low_sample_restarts: assert property (p_low_sample_restarts)
      else $error("Low sample did not restart qualification.");
endmodule

// ---- core/current_monitor_avg_ocdelay_ctrl.sv ----
// Overview of operation
// - Alert enable bit 3 low keeps alert off and ignores alert response.
// - Bits 2:0 pick 1 to 128 samples averaged, power of two.
// - Unassigned control bits carry no meaning; host must not test them.
// - Delay byte bit 7 holds counters reset, no events, clears flags.
// - With bit 7 low, seven-bit delay applies to every channel.
// - Flag sets after consecutive exceeding samples; any low sample restarts.
// - Delay zero sets flag and alert on first exceeding sample.
// - Flag stays set until host writes zero or sets delay byte bit 7; sets again only on new excursion, or on one still running when bit 7 clears.
// - Any status byte read or write deasserts the alert output, unless a new event lands in the same cycle.
module current_monitor_avg_ocdelay_ctrl (
   input wire logic i_clk, // 125 MHz clock.
   input wire logic i_nrst, // Sync reset, active low.
   input wire logic [7:0] i_cmd_code, // Command code of access.
   input wire logic i_wr_stb, // Byte write pulse.
   input wire logic [7:0] i_wr_data, // Byte to write.
   input wire logic i_rd_stb, // Byte read pulse.
   input wire logic i_ara_won, // Alert response won.
   input wire logic [ocmon_pkg::NUM_CH-1:0] i_sample_stb, // Sample ticks.
   input wire logic [ocmon_pkg::NUM_CH-1:0] i_over_thresh, // Over threshold.
   output logic [7:0] o_rd_data, // Read byte.
   output logic o_rd_valid, // Read byte valid pulse.
   output logic o_alert, // Alert, active high.
   output logic o_ara_respond_en, // Answer alert response.
   output logic [ocmon_pkg::AVG_W-1:0] o_average_count_select, // Averaging.
   output logic [ocmon_pkg::DLY_W-1:0] o_qualify_delay_value, // Delay value.
   output logic [ocmon_pkg::NUM_CH-1:0] o_overcurrent_flag // Flags.
);
   import ocmon_pkg::*;

   function automatic logic cmd_hit(input logic [7:0] code,
                                    input logic [7:0] sel);
      cmd_hit = (code == sel);
   endfunction

   logic alert_en_q;
   logic cnt_reset_q;
   logic [NUM_CH-1:0] qual;
   logic [NUM_CH-1:0] event_hit;
   logic status_access;
   logic [NUM_CH-1:0] flag_clr;

   assign status_access = (i_wr_stb || i_rd_stb) && cmd_hit(i_cmd_code,
                                                           CMD_STATUS);
   assign flag_clr = (i_wr_stb && cmd_hit(i_cmd_code, CMD_STATUS)) ?
                     ~i_wr_data[NUM_CH-1:0] : '0;
   assign event_hit = qual & {NUM_CH{~cnt_reset_q}};

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         alert_en_q <= CONFIG_RST[ALERT_EN_BIT];
         o_ara_respond_en <= CONFIG_RST[ALERT_EN_BIT];
         o_average_count_select <= CONFIG_RST[AVG_LSB +: AVG_W];
      end else if (i_wr_stb && cmd_hit(i_cmd_code, CMD_CONFIG)) begin
         alert_en_q <= i_wr_data[ALERT_EN_BIT];
         o_ara_respond_en <= i_wr_data[ALERT_EN_BIT];
         o_average_count_select <= i_wr_data[AVG_LSB +: AVG_W];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cnt_reset_q <= QDELAY_RST[CNT_RESET_BIT];
         o_qualify_delay_value <= QDELAY_RST[QDLY_LSB +: DLY_W];
      end else if (i_wr_stb && cmd_hit(i_cmd_code, CMD_QDELAY)) begin
         cnt_reset_q <= i_wr_data[CNT_RESET_BIT];
         o_qualify_delay_value <= i_wr_data[QDLY_LSB +: DLY_W];
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         oc_qualifier u_qual (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_hold(cnt_reset_q),
            .i_delay(o_qualify_delay_value),
            .i_sample_stb(i_sample_stb[ch]),
            .i_over(i_over_thresh[ch]),
            .o_qualified(qual[ch])
         );
      end
   endgenerate

   // A new event in the clearing cycle wins, so no excursion is lost.
   always_ff @(posedge i_clk) begin
      if (!i_nrst || cnt_reset_q) begin
         o_overcurrent_flag <= '0;
      end else begin
         o_overcurrent_flag <= (o_overcurrent_flag & ~flag_clr)
                               | event_hit;
      end
   end

   // Alert is set by qualified events only while enabled; a status access or a won
   // alert response drops it, but a fresh event in that cycle keeps it.
   always_ff @(posedge i_clk) begin
      if (!i_nrst || !alert_en_q) begin
         o_alert <= 1'b0;
      end else if (|event_hit) begin
         o_alert <= 1'b1;
      end else if (status_access || i_ara_won) begin
         o_alert <= 1'b0;
      end
   end

   // Unassigned bits read as zero; the host must not depend on that.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_rd_data <= 8'h00;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= i_rd_stb;
         if (i_rd_stb) begin
            unique case (i_cmd_code)
               CMD_STATUS: o_rd_data <= {4'h0, o_overcurrent_flag};
               CMD_CONFIG: o_rd_data <= {4'h0, alert_en_q,
                                         o_average_count_select};
               CMD_QDELAY: o_rd_data <= {cnt_reset_q, o_qualify_delay_value};
               default: o_rd_data <= 8'h00;
            endcase
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   property p_alert_off_disabled;
      !alert_en_q |=> !o_alert;
   endproperty
   a_alert_off_disabled: assert property (p_alert_off_disabled)
      else $error("Alert driven while disabled.");

   property p_ara_follows_write;
      i_wr_stb && i_cmd_code == CMD_CONFIG
         |=> o_ara_respond_en == $past(i_wr_data[ALERT_EN_BIT]);
   endproperty
   a_ara_follows_write: assert property (p_ara_follows_write)
      else $error("Alert response enable did not follow control write.");

   property p_avg_select;
      i_wr_stb && i_cmd_code == CMD_CONFIG
         |=> o_average_count_select == $past(i_wr_data[2:0]);
   endproperty
   a_avg_select: assert property (p_avg_select)
      else $error("Averaging select not taken from control write.");

   property p_reserved_zero;
      i_rd_stb && i_cmd_code == CMD_CONFIG |=> o_rd_data[7:4] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("Unassigned control bits read nonzero.");

   property p_hold_clears;
      cnt_reset_q |=> o_overcurrent_flag == '0 ##1 o_overcurrent_flag == '0;
   endproperty
   a_hold_clears: assert property (p_hold_clears)
      else $error("Flags not cleared under counter reset.");

   property p_event_sets_flag;
      |event_hit |=> (o_overcurrent_flag & $past(event_hit))
                     == $past(event_hit);
   endproperty
   a_event_sets_flag: assert property (p_event_sets_flag)
      else $error("Qualified event did not set its flag.");

   property p_flag_sticky;
      o_overcurrent_flag[0] && !flag_clr[0] && !cnt_reset_q
         |=> o_overcurrent_flag[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("Flag dropped without a zero write.");

   property p_no_flag_without_event;
      !o_overcurrent_flag[0] && !event_hit[0] |=> !o_overcurrent_flag[0];
   endproperty
   a_no_flag_without_event: assert property (p_no_flag_without_event)
      else $error("Flag set without a qualified event.");

   property p_status_drops_alert;
      status_access && !(|event_hit) |=> !o_alert;
   endproperty
   a_status_drops_alert: assert property (p_status_drops_alert)
      else $error("Status access did not deassert alert.");

   property p_alert_on_event;
      alert_en_q && |event_hit |=> o_alert;
   endproperty
   a_alert_on_event: assert property (p_alert_on_event)
      else $error("Enabled alert not asserted on event.");

   property p_ara_won_drops;
      i_ara_won && !(|event_hit) |=> !o_alert;
   endproperty
   a_ara_won_drops: assert property (p_ara_won_drops)
      else $error("Won alert response did not deassert alert.");

   property p_delay_follows_write;
      i_wr_stb && i_cmd_code == CMD_QDELAY
         |=> o_qualify_delay_value == $past(i_wr_data[QDLY_LSB +: DLY_W])
             && cnt_reset_q == $past(i_wr_data[CNT_RESET_BIT]);
   endproperty
   a_delay_follows_write: assert property (p_delay_follows_write)
      else $error("Delay byte not taken from write.");

   property p_hold_no_event;
      cnt_reset_q |-> event_hit == '0;
   endproperty
   a_hold_no_event: assert property (p_hold_no_event)
      else $error("Overcurrent event produced under counter reset.");

   property p_status_read_data;
      i_rd_stb && i_cmd_code == CMD_STATUS
         |=> o_rd_valid && o_rd_data == {4'h0, $past(o_overcurrent_flag)};
   endproperty
   a_status_read_data: assert property (p_status_read_data)
      else $error("Status read did not return the flags.");

   c_flag_set: cover property (|event_hit ##1 o_alert);
   c_flag_cleared: cover property (o_overcurrent_flag[0] ##1
                                   !o_overcurrent_flag[0]);
   c_hold_active: cover property (cnt_reset_q && |i_over_thresh);
   c_status_read: cover property (o_alert ##0 status_access ##1 !o_alert);
endmodule

// ---- bench/smbus_host_model.sv ----
module smbus_host_model (
   input wire logic i_clk, // Clock.
   input wire logic [7:0] i_rd_data, // Read byte.
   input wire logic i_rd_valid, // Read byte valid.
   output logic [7:0] o_cmd_code, // Command code.
   output logic o_wr_stb, // Write pulse.
   output logic [7:0] o_wr_data, // Write byte.
   output logic o_rd_stb // Read pulse.
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_cmd_code = 8'h00;
      o_wr_stb = 1'b0;
      o_wr_data = 8'h00;
      o_rd_stb = 1'b0;
   end
   // Requests change only at the falling edge, one byte each.
   task automatic wr(input logic [7:0] code, input logic [7:0] data);
      @(negedge i_clk);
      o_cmd_code = code;
      o_wr_data = data;
      o_wr_stb = 1'b1;
      @(negedge i_clk);
      o_wr_stb = 1'b0;
      o_wr_data = ~data;
      @(negedge i_clk);
   endtask
   // A missing valid pulse returns an unknown, which never matches.
   task automatic rd(input logic [7:0] code, output logic [7:0] data);
      @(negedge i_clk);
      o_cmd_code = code;
      o_rd_stb = 1'b1;
      @(negedge i_clk);
      o_rd_stb = 1'b0;
      data = (i_rd_valid === 1'b1) ? i_rd_data : 8'hXX;
      @(negedge i_clk);
   endtask
endmodule

// ---- bench/current_monitor_avg_ocdelay_ctrl_tb_top.sv ----
module current_monitor_avg_ocdelay_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ocmon_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, ara_won = 1'b0;
   logic [NUM_CH-1:0] stb = '0, over = '0, flag;
   logic [7:0] cmd, wdat, rdat, v;
   logic wstb, rstb, rval, alert, ara_en;
   logic [AVG_W-1:0] avg;
   logic [DLY_W-1:0] dly;
   int failures = 0, n_compared = 0;
   always #4 clk = ~clk;
   current_monitor_avg_ocdelay_ctrl uut (.i_clk(clk), .i_nrst(nrst),
      .i_cmd_code(cmd), .i_wr_stb(wstb), .i_wr_data(wdat),
      .i_rd_stb(rstb), .i_ara_won(ara_won), .i_sample_stb(stb),
      .i_over_thresh(over), .o_rd_data(rdat), .o_rd_valid(rval),
      .o_alert(alert), .o_ara_respond_en(ara_en),
      .o_average_count_select(avg), .o_qualify_delay_value(dly),
      .o_overcurrent_flag(flag));
   smbus_host_model host (.i_clk(clk), .i_rd_data(rdat),
      .i_rd_valid(rval), .o_cmd_code(cmd), .o_wr_stb(wstb),
      .o_wr_data(wdat), .o_rd_stb(rstb));
   task automatic chk(input logic [7:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Flag and alert together: {alert, 3'b0, flags}.
   task automatic chk_fa(input logic [3:0] f, input logic a);
      chk({alert, 3'h0, flag}, {a, 3'h0, f}, "flags/alert");
   endtask
   // One sample, then wt more cycles for the flag to show.
   task automatic smp(input int ch, input logic ov, input int wt);
      @(negedge clk);
      stb[ch] = 1'b1;
      over[ch] = ov;
      @(negedge clk);
      stb = '0;
      over = '0;
      repeat (wt) @(negedge clk);
   endtask
   task automatic conclude();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #200us;
      failures++;
      conclude();
   end
   initial begin
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      chk({7'h0, ara_en}, 8'h01, "ara en");
      chk({5'h0, avg}, 8'h04, "avg");
      host.rd(CMD_CONFIG, v);
      chk(v & 8'h0F, 8'h0C, "config");
      host.rd(CMD_QDELAY, v);
      chk(v, 8'h04, "delay");
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         host.wr(CMD_CONFIG, {5'b00001, c[2:0]});
         chk({5'h0, avg}, {5'h0, c[2:0]}, "avg sel");
         host.rd(CMD_CONFIG, v);
         chk(v & 8'h0F, {5'b00001, c[2:0]}, "config rd");
      end
      $display("test averaging done");
      host.wr(CMD_QDELAY, 8'h00);
      smp(1, 1'b1, 2);
      chk_fa(4'b0010, 1'b1);
      host.rd(CMD_STATUS, v);
      chk(v, 8'h02, "status");
      chk_fa(4'b0010, 1'b0);
      host.wr(CMD_STATUS, 8'h0F);
      chk_fa(4'b0010, 1'b0);
      host.wr(CMD_STATUS, 8'h00);
      chk_fa(4'b0000, 1'b0);
      $display("test zero delay done");
      host.wr(CMD_QDELAY, 8'h03);
      repeat (3) smp(0, 1'b1, 0);
      smp(0, 1'b0, 0);
      repeat (3) smp(0, 1'b1, 2);
      chk_fa(4'b0000, 1'b0);
      smp(0, 1'b1, 2);
      chk_fa(4'b0001, 1'b1);
      @(negedge clk);
      ara_won = 1'b1;
      @(negedge clk);
      ara_won = 1'b0;
      @(negedge clk);
      chk_fa(4'b0001, 1'b0);
      repeat (4) smp(0, 1'b1, 2);
      chk_fa(4'b0001, 1'b0);
      // Lowering the delay in mid-excursion must not wait for a wrap.
      smp(0, 1'b0, 0);
      repeat (2) smp(0, 1'b1, 0);
      host.wr(CMD_QDELAY, 8'h01);
      smp(0, 1'b1, 2);
      chk_fa(4'b0001, 1'b1);
      host.wr(CMD_STATUS, 8'h00);
      $display("test delay count done");
      host.wr(CMD_CONFIG, 8'h04);
      chk({7'h0, ara_en}, 8'h00, "ara off");
      host.wr(CMD_QDELAY, 8'h00);
      smp(2, 1'b1, 2);
      chk_fa(4'b0100, 1'b0);
      host.wr(CMD_QDELAY, 8'h80);
      chk_fa(4'b0000, 1'b0);
      smp(3, 1'b1, 2);
      chk_fa(4'b0000, 1'b0);
      host.wr(CMD_QDELAY, 8'h02);
      chk({1'b0, dly}, 8'h02, "delay val");
      repeat (2) smp(3, 1'b1, 2);
      chk_fa(4'b0000, 1'b0);
      smp(3, 1'b1, 2);
      chk_fa(4'b1000, 1'b0);
      $display("test counter reset done");
      @(negedge clk);
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      chk_fa(4'b0000, 1'b0);
      chk({1'b0, dly}, 8'h04, "delay rst");
      chk({7'h0, ara_en}, 8'h01, "ara rst");
      host.rd(8'h03, v);
      chk(v, 8'h00, "unknown code");
      $display("test mid-run reset done");
      conclude();
   end
endmodule
